// ---- twcwd_top.sv ----
// watchdog reset for the two-wire output-only interface mode
// assumes all pins are asynchronous to core_clk and get synchronised here
`timescale 1ns/1ps
`include "twcwd_map.svh"
module twcwd_top #(
  parameter int TIMEOUT_CYC = `TWCWD_TIMEOUT_CYC,
  parameter int PULSE_CYC   = `TWCWD_RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // pins
  input  wire logic                     serial_clk_pin,
  input  wire logic                     interface_select_pin,
  input  wire logic                     oversampling_select_bit0,
  input  wire logic                     oversampling_select_bit1,
  input  wire logic                     boost_select,
  input  wire logic                     ch0_gain_select_bit0,
  input  wire logic                     ch0_gain_select_bit1,
  // outputs
  output logic                          two_wire_mode,
  output logic                          chip_reset,
  output logic                          hard_reset,
  output twcwd_pkg::twcwd_cfg_t         cfg
);
  // ==========================================
  // synchronisers
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic       sck_d;
  logic       sel_d;
  always_ff @(posedge core_clk) begin
    sync1 <= {serial_clk_pin, interface_select_pin, oversampling_select_bit0,
              oversampling_select_bit1, boost_select, ch0_gain_select_bit0,
              ch0_gain_select_bit1};
    sync2 <= sync1;
  end
  // synchronised levels, positions as packed into sync1 above
  wire sck       = sync2[`TWCWD_POS_SCK];
  wire sel       = sync2[`TWCWD_POS_SEL];
  wire os_bit0   = sync2[`TWCWD_POS_OS_BIT0];
  wire os_bit1   = sync2[`TWCWD_POS_OS_BIT1];
  wire boost_bit = sync2[`TWCWD_POS_BOOST];
  wire gain_bit0 = sync2[`TWCWD_POS_GAIN_BIT0];
  wire gain_bit1 = sync2[`TWCWD_POS_GAIN_BIT1];
  // edges of synchronised levels only, never of raw pins
  wire sck_ris   = sck & ~sck_d;
  wire sel_ris   = sel & ~sel_d;
  // configuration word as the pins show it now
  twcwd_pkg::twcwd_cfg_t pin_cfg;
  assign pin_cfg = '{ch0_gain: {gain_bit1, gain_bit0},
                     boost:    boost_bit,
                     osr:      {os_bit1, os_bit0}};
  // ==========================================
  // watchdog timer
  twcwd_pkg::twcwd_state_t state;
  twcwd_pkg::twcwd_state_t next_state;
  logic [`TWCWD_CNT_W-1:0] cnt;
  logic [`TWCWD_CNT_W-1:0] pcnt;
  logic                    in_reset;
  // counter has reached a limit; shared by timeout and pulse length
  function automatic logic reached(input logic [`TWCWD_CNT_W-1:0] c, input int lim);
    return c >= `TWCWD_CNT_W'(lim);
  endfunction
  // cnt holds whole cycles spent high since the timer started
  wire timeout    = reached(cnt, TIMEOUT_CYC);
  wire pulse_done = reached(pcnt, PULSE_CYC - 1);
  always_comb begin
    next_state = state;
    case (state)
      twcwd_pkg::TWCWD_IDLE: begin
        if (two_wire_mode && sck_ris) next_state = twcwd_pkg::TWCWD_TIMING; // see RULE2
      end
      twcwd_pkg::TWCWD_TIMING: begin
        if (!two_wire_mode || !sck) next_state = twcwd_pkg::TWCWD_IDLE;     // see RULE4 see RULE11
        else if (timeout) next_state = twcwd_pkg::TWCWD_FIRE;              // see RULE3
      end
      twcwd_pkg::TWCWD_FIRE: begin
        if (pulse_done) next_state = twcwd_pkg::TWCWD_IDLE;
      end
      default: next_state = twcwd_pkg::TWCWD_IDLE;
    endcase
  end
  wire fire = (state == twcwd_pkg::TWCWD_FIRE);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= twcwd_pkg::TWCWD_IDLE;
      cnt   <= '0;
      pcnt  <= '0;
    end else begin
      state <= next_state;
      // counter runs only while high and timing; see RULE6
      cnt   <= (next_state == twcwd_pkg::TWCWD_TIMING && state == twcwd_pkg::TWCWD_TIMING)
               ? cnt + 1'b1 : '0;
      pcnt  <= fire ? pcnt + 1'b1 : '0;
    end
  end
  // ==========================================
  // edge detector history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sck_d <= sck;
      sel_d <= sel;
    end
  end
  // ==========================================
  // mode latch on leaving a reset
  // rst just released, or a watchdog pulse just ended
  wire reset_exit = in_reset & ~fire;
  // reset pin released while it still acts as hard reset
  wire hard_exit  = hard_reset & os_bit0 & ~two_wire_mode;
  wire latch_mode = reset_exit | hard_exit;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_reset      <= 1'b1;
      two_wire_mode <= 1'b0;
    end else begin
      in_reset <= fire;
      if (latch_mode) two_wire_mode <= sel; // see RULE8
    end
  end
  // ==========================================
  // reset outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chip_reset <= 1'b1;
      hard_reset <= 1'b0;
    end else begin
      chip_reset <= fire;
      // reset pin acts as hard reset only outside two-wire mode; see RULE1
      // held off while the mode is latched, so no stray pulse after reset
      hard_reset <= ~two_wire_mode & ~os_bit0 & ~in_reset;
    end
  end
  // ==========================================
  // configuration capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= `TWCWD_CFG_RST;
    end else if (fire) begin
      cfg <= `TWCWD_CFG_RST; // see RULE3
    end else if (two_wire_mode && sel_ris) begin
      cfg <= pin_cfg; // see RULE9
    end
  end
  // ==========================================
  // checks
  property p_fire_after_high;
    @(posedge core_clk) disable iff (rst)
      (state == twcwd_pkg::TWCWD_TIMING && timeout && sck && two_wire_mode)
      |=> fire ##1 chip_reset;
  endproperty
  a_fire_after_high: assert property (p_fire_after_high) else $error("no reset on timeout"); // see RULE3
  property p_low_clears;
    @(posedge core_clk) disable iff (rst)
      (state == twcwd_pkg::TWCWD_TIMING && !sck) |=> state == twcwd_pkg::TWCWD_IDLE ##1 cnt == 0;
  endproperty
  a_low_clears: assert property (p_low_clears) else $error("timer not cleared on low"); // see RULE4
  property p_low_no_fire;
    @(posedge core_clk) disable iff (rst)
      (!sck && !$past(sck) && state != twcwd_pkg::TWCWD_FIRE) |=> !fire;
  endproperty
  a_low_no_fire: assert property (p_low_no_fire) else $error("reset while clock low"); // see RULE6
  property p_spi_idle;
    @(posedge core_clk) disable iff (rst)
      (!two_wire_mode && state != twcwd_pkg::TWCWD_FIRE) |=> !fire;
  endproperty
  a_spi_idle: assert property (p_spi_idle) else $error("watchdog active in spi mode"); // see RULE11
  property p_start_on_rise;
    @(posedge core_clk) disable iff (rst)
      (state == twcwd_pkg::TWCWD_IDLE && two_wire_mode && sck_ris)
      |=> state == twcwd_pkg::TWCWD_TIMING;
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("timer not started"); // see RULE2
  property p_no_hard_in_2w;
    @(posedge core_clk) disable iff (rst)
      $past(two_wire_mode) |-> !hard_reset;
  endproperty
  a_no_hard_in_2w: assert property (p_no_hard_in_2w) else $error("hard reset in two-wire"); // see RULE1
  property p_mode_latch;
    @(posedge core_clk) disable iff (rst)
      (in_reset && !fire) |=> two_wire_mode == $past(sel);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched"); // see RULE8
  // mode and configuration
  property p_cfg_capture;
    @(posedge core_clk) disable iff (rst)
      (two_wire_mode && sel_ris && !fire)
      |=> cfg.osr == {$past(os_bit1), $past(os_bit0)} ##0 $stable(two_wire_mode);
  endproperty
  a_cfg_capture: assert property (p_cfg_capture) else $error("config not captured"); // see RULE9
  property p_gain_capture;
    @(posedge core_clk) disable iff (rst)
      (two_wire_mode && sel_ris && !fire)
      |=> cfg.ch0_gain == {$past(gain_bit1), $past(gain_bit0)} && cfg.boost == $past(boost_bit);
  endproperty
  a_gain_capture: assert property (p_gain_capture) else $error("gain or boost not captured"); // see RULE9
  property p_hard_exit_latch;
    @(posedge core_clk) disable iff (rst)
      (hard_reset && os_bit0 && !two_wire_mode) |=> two_wire_mode == $past(sel) && !hard_reset;
  endproperty
  a_hard_exit_latch: assert property (p_hard_exit_latch) else $error("mode not latched"); // see RULE8
  // reset outputs
  property p_hard_follows_pin;
    @(posedge core_clk) disable iff (rst)
      (!two_wire_mode && !in_reset && !os_bit0) |=> hard_reset;
  endproperty
  a_hard_follows_pin: assert property (p_hard_follows_pin) else $error("no hard reset"); // see RULE1
  property p_pulse_len;
    @(posedge core_clk) disable iff (rst)
      $fell(fire) |-> $past(pcnt) == `TWCWD_CNT_W'(PULSE_CYC - 1);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong"); // see RULE3
  // timer behaviour
  property p_fire_needs_high;
    @(posedge core_clk) disable iff (rst)
      $rose(fire) |-> $past(sck) && $past(timeout) && $past(two_wire_mode);
  endproperty
  a_fire_needs_high: assert property (p_fire_needs_high) else $error("reset without high"); // see RULE6
  property p_idle_cleared;
    @(posedge core_clk) disable iff (rst)
      (state == twcwd_pkg::TWCWD_IDLE) |-> cnt == '0;
  endproperty
  a_idle_cleared: assert property (p_idle_cleared) else $error("timer not clear in idle"); // see RULE4
endmodule

// ---- twcwd_map.svh ----
// timing and field constants for the two-wire clock watchdog
// assumes a 100 MHz core clock sampling all pins
//
// Operation
// RULE1 - In two-wire mode the reset pin gives no hard reset and serves as oversampling bit zero.
// RULE2 - In two-wire mode the watchdog timer starts on every rising edge of the serial clock.
// RULE3 - A clock high longer than the timeout causes a full chip reset of settings and channels.
// RULE4 - A clock that falls before the timeout clears the timer until the next rising edge.
// RULE5 - The host clocks at 138.9 kHz or more, one over twice the 3.6 us minimum timeout.
// RULE6 - A clock held low never causes a watchdog reset, however long.
// RULE7 - To leave two-wire mode the host drives interface select low and holds it through the reset.
// RULE8 - The interface mode is latched from interface select when leaving any reset.
// RULE9 - In two-wire mode the five configuration pins are captured on the interface select rise.
// RULE10 - The host keeps the clock toggling continuously in two-wire mode.
// RULE11 - In serial peripheral interface mode the watchdog stays cleared and cannot reset the chip.
`ifndef TWCWD_MAP_SVH
`define TWCWD_MAP_SVH
// ==========================================
// timing
`define TWCWD_CLK_PERIOD_NS  10
`define TWCWD_TIMEOUT_NS     3600
`define TWCWD_TIMEOUT_CYC    ((`TWCWD_TIMEOUT_NS + `TWCWD_CLK_PERIOD_NS - 1) / `TWCWD_CLK_PERIOD_NS)
`define TWCWD_CNT_W          12
`define TWCWD_RST_PULSE_CYC  4
// ==========================================
// configuration word fields
`define TWCWD_CFG_W          5
`define TWCWD_CFG_RST        5'h00
// ==========================================
// synchroniser bit positions
`define TWCWD_POS_SCK        6
`define TWCWD_POS_SEL        5
`define TWCWD_POS_OS_BIT0    4
`define TWCWD_POS_OS_BIT1    3
`define TWCWD_POS_BOOST      2
`define TWCWD_POS_GAIN_BIT0  1
`define TWCWD_POS_GAIN_BIT1  0
`endif

// ---- twcwd_pkg.sv ----
// types for the two-wire clock watchdog
// assumes twcwd_map.svh is on the include path
`include "twcwd_map.svh"
package twcwd_pkg;
  // ==========================================
  // captured configuration
  typedef struct packed {
    logic [1:0] ch0_gain;
    logic       boost;
    logic [1:0] osr;
  } twcwd_cfg_t;
  typedef enum logic [1:0] {
    TWCWD_IDLE,
    TWCWD_TIMING,
    TWCWD_FIRE
  } twcwd_state_t;
endpackage

// ---- twcwd_host.sv ----
// host model driving the serial clock pin
// assumes a free 125 ns clock only while run is high
`timescale 1ns/1ps
module twcwd_host (
  // control
  input  wire logic run,
  input  wire logic level,
  // pin
  output logic      sck
);
  // ==========================================
  // clock or held level
  initial sck = 1'b0;
  always begin
    #62.5;
    sck = run ? ~sck : level;
  end
endmodule

// ---- test_two_wire_clock_watchdog_reset.sv ----
// bench for the two-wire clock watchdog reset
// assumes twcwd_top and twcwd_host are compiled first
`timescale 1ns/1ps
module test_two_wire_clock_watchdog_reset;
  localparam int TO = 20;
  logic                  core_clk = 1'b0;
  logic                  rst      = 1'b1;
  logic                  run      = 1'b0;
  logic                  level    = 1'b0;
  logic                  sel      = 1'b0;
  logic [4:0]            pins     = 5'h00;
  logic                  sck;
  logic                  two_wire_mode;
  logic                  chip_reset;
  logic                  hard_reset;
  twcwd_pkg::twcwd_cfg_t cfg;
  logic [15:0]           n;
  int                    n_errors = 0;
  int                    compares = 0;
  always #5 core_clk = ~core_clk;
  twcwd_host i_host (.run(run), .level(level), .sck(sck));
  twcwd_top #(.TIMEOUT_CYC(TO), .PULSE_CYC(4)) i_dut (
    .core_clk(core_clk), .rst(rst), .serial_clk_pin(sck), .interface_select_pin(sel),
    .oversampling_select_bit0(pins[0]), .oversampling_select_bit1(pins[1]),
    .boost_select(pins[2]), .ch0_gain_select_bit0(pins[3]), .ch0_gain_select_bit1(pins[4]),
    .two_wire_mode(two_wire_mode), .chip_reset(chip_reset), .hard_reset(hard_reset),
    .cfg(cfg));
  // ==========================================
  // helpers
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // cycles until chip reset, or lim
  task automatic watch(int lim, output logic [15:0] k);
    k = 0;
    while (chip_reset !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_spi;
    chk(chip_reset, 1'b1);
    rst = 1'b0;
    cyc(3);
    chk(two_wire_mode, 1'b0);
    chk(hard_reset, 1'b1);
    level = 1'b1;
    watch(100, n);
    chk(n, 16'h0064);
    // releasing the reset pin leaves hard reset and latches the mode
    sel  = 1'b1;
    pins = 5'h01;
    cyc(5);
    chk(two_wire_mode, 1'b1);
    chk(hard_reset, 1'b0);
    $display("spi mode done");
  endtask
  task automatic t_enter;
    sel = 1'b1;
    run = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(3);
    chk(two_wire_mode, 1'b1);
    sel = 1'b0;
    cyc(4);
    pins = 5'h16;
    sel = 1'b1;
    cyc(6);
    chk(cfg, 5'h16);
    chk(hard_reset, 1'b0);
    watch(300, n);
    chk(n, 16'h012c);
    run = 1'b0;
    level = 1'b0;
    watch(600, n);
    chk(n, 16'h0258);
    $display("enter and run done");
  endtask
  task automatic t_fire;
    level = 1'b1;
    @(posedge sck);
    watch(TO + 20, n);
    chk(n >= TO && n <= TO + 8, 1'b1);
    n = 0;
    while (chip_reset === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(n, 16'h0004);
    cyc(2);
    chk(cfg, 5'h00);
    chk(two_wire_mode, 1'b1);
    $display("watchdog fire done");
  endtask
  task automatic t_exit;
    run = 1'b1;
    cyc(50);
    sel = 1'b0;
    run = 1'b0;
    watch(TO + 60, n);
    chk(n < TO + 60, 1'b1);
    cyc(8);
    chk(two_wire_mode, 1'b0);
    $display("exit done");
  endtask
  initial begin
    cyc(8);
    t_spi();
    t_enter();
    t_fire();
    t_exit();
    end_sim();
  end
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
endmodule
